// [verilog/ipdp_cfg.svh]
`ifndef IPDP_CFG_SVH
`define IPDP_CFG_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define IPDP_OFS_LIMIT_LOW   12'h060
`define IPDP_OFS_LIMIT_HIGH  12'h061
`define IPDP_OFS_AVG_CTRL    12'h062
`define IPDP_OFS_POWER_LOW   12'h063
`define IPDP_OFS_POWER_HIGH  12'h064

// ----------------------------------------------------------------
// field layout and reset values
// ----------------------------------------------------------------
`define IPDP_ENABLE_BIT      7
`define IPDP_EXP_MSB         3
`define IPDP_HIGH_MSB        4
`define IPDP_LIMIT_RESET     13'h0000
`define IPDP_EXP_RESET       4'h0
`define IPDP_RDATA_RESET     8'h00

// ----------------------------------------------------------------
// arithmetic
// ----------------------------------------------------------------
`define IPDP_DATA_MSB        15
`define IPDP_DATA_LSB        10
`define IPDP_WIN_BASE        5'h09
`define IPDP_EXP_MAX         4'ha

`endif

// [verilog/ipdp_pkg.sv]
package ipdp_pkg;

   typedef struct packed {
      logic [11:0] power;
      logic        valid;
   } ipdp_calc_state_t;

   typedef struct packed {
      logic [12:0] limit;
      logic        avg_on;
      logic [3:0]  win_exp;
      logic [30:0] acc;
      logic [18:0] cnt;
      logic [12:0] level;
      logic        flag;
      logic [7:0]  rdata;
   } ipdp_core_state_t;

endpackage

// [verilog/ipdp_calc_if.sv]
`timescale 1ns/10ps

interface ipdp_calc_if;
   logic [15:0] i_sample;
   logic [15:0] q_sample;
   logic        sample_valid;
   logic [11:0] power;
   logic        power_valid;

   modport calc (
      input  i_sample,
      input  q_sample,
      input  sample_valid,
      output power,
      output power_valid
   );

   modport core (
      output i_sample,
      output q_sample,
      output sample_valid,
      input  power,
      input  power_valid
   );
endinterface

// [verilog/ipdp_power_calc.sv]
`timescale 1ns/10ps
`include "ipdp_cfg.svh"

module ipdp_power_calc (
   input wire logic clock_i,
   input wire logic srst_i,
   ipdp_calc_if.calc cif
);

   ipdp_pkg::ipdp_calc_state_t state_r;
   ipdp_pkg::ipdp_calc_state_t state_nxt;

   logic signed [5:0]  i_top;
   logic signed [5:0]  q_top;
   logic signed [11:0] i_sq;
   logic signed [11:0] q_sq;

   // ----------------------------------------------------------------
   // i^2 + q^2 on the six top bits
   // ----------------------------------------------------------------
   always_comb begin
      i_top = cif.i_sample[`IPDP_DATA_MSB:`IPDP_DATA_LSB];
      q_top = cif.q_sample[`IPDP_DATA_MSB:`IPDP_DATA_LSB];
      i_sq  = i_top * i_top;
      q_sq  = q_top * q_top;
      state_nxt       = state_r;
      state_nxt.valid = cif.sample_valid;
      if (cif.sample_valid) begin
         // both squares are at most 1024, so the sum fits 12 bits
         state_nxt.power = 12'(unsigned'(i_sq) + unsigned'(q_sq));
      end
   end

   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign cif.power       = state_r.power;
   assign cif.power_valid = state_r.valid;

endmodule

// [verilog/ipdp_top.sv]
`timescale 1ns/10ps
`include "ipdp_cfg.svh"

// Notes on behaviour
// - a 13-bit power limit is kept, low byte at one offset and five upper bits at the next.
// - when the averaged power crosses the limit the overpower guard flag goes high.
// - averaging runs only while the enable bit 7 of the averaging control register is one.
// - the window exponent (0 to 10) averages over 2^(9+exp) I/Q pairs.
// - before the limit is crossed the measured power reads the current average.
// - once crossed the readback freezes at the peak until the power interrupt is cleared.
// - only the six top bits of each I and Q sample feed the power calculation.

module ipdp_top (
   input  wire logic        clock_i,
   input  wire logic        srst_i,
   input  wire logic [15:0] i_sample_i,
   input  wire logic [15:0] q_sample_i,
   input  wire logic        sample_valid_i,
   input  wire logic [11:0] reg_addr_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [7:0]  reg_wdata_i,
   input  wire logic        irq_clear_i,
   output      logic [7:0]  reg_rdata_o,
   output      logic        overpower_guard_flag_o
);

   ipdp_pkg::ipdp_core_state_t state_r;
   ipdp_pkg::ipdp_core_state_t state_nxt;

   ipdp_calc_if cif ();

   assign cif.i_sample     = i_sample_i;
   assign cif.q_sample     = q_sample_i;
   assign cif.sample_valid = sample_valid_i;

   ipdp_power_calc u_calc (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .cif     (cif)
   );

   logic [3:0]  exp_eff;
   logic [4:0]  win_shift;
   logic [18:0] cnt_last;
   logic [30:0] acc_sum;
   logic [12:0] new_avg;
   logic        win_done;
   logic        crossed;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;

      // out-of-range exponents act as the largest window
      exp_eff   = (state_r.win_exp > `IPDP_EXP_MAX) ? `IPDP_EXP_MAX : state_r.win_exp;
      win_shift = `IPDP_WIN_BASE + 5'(exp_eff);
      cnt_last  = 19'((32'h1 << win_shift) - 32'h1);
      acc_sum   = state_r.acc + 31'(cif.power);
      // block average: a true sliding window would need 2^19 samples of history
      new_avg   = 13'(acc_sum >> win_shift);
      win_done  = state_r.avg_on && cif.power_valid && (state_r.cnt == cnt_last);
      crossed   = win_done && (new_avg > state_r.limit);

      // averaging engine
      if (!state_r.avg_on) begin
         state_nxt.acc = '0;
         state_nxt.cnt = '0;
      end else if (cif.power_valid) begin
         if (win_done) begin
            state_nxt.acc = '0;
            state_nxt.cnt = '0;
         end else begin
            state_nxt.acc = acc_sum;
            state_nxt.cnt = state_r.cnt + 19'h1;
         end
      end

      // readback level: live or frozen peak
      if (win_done) begin
         if (state_r.flag || crossed) begin
            if (new_avg > state_r.level || !state_r.flag) begin
               state_nxt.level = new_avg;
            end
         end else begin
            state_nxt.level = new_avg;
         end
      end

      // flag: a crossing in the clear cycle wins
      if (crossed) begin
         state_nxt.flag = 1'b1;
      end else if (irq_clear_i) begin
         state_nxt.flag = 1'b0;
      end

      // register writes
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            `IPDP_OFS_LIMIT_LOW: begin
               state_nxt.limit[7:0] = reg_wdata_i;
            end
            `IPDP_OFS_LIMIT_HIGH: begin
               state_nxt.limit[12:8] = reg_wdata_i[`IPDP_HIGH_MSB:0];
            end
            `IPDP_OFS_AVG_CTRL: begin
               state_nxt.avg_on  = reg_wdata_i[`IPDP_ENABLE_BIT];
               state_nxt.win_exp = reg_wdata_i[`IPDP_EXP_MSB:0];
            end
            default: begin
            end
         endcase
      end

      // register reads, one cycle latency, unmapped reads zero
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            `IPDP_OFS_LIMIT_LOW: begin
               state_nxt.rdata = state_r.limit[7:0];
            end
            `IPDP_OFS_LIMIT_HIGH: begin
               state_nxt.rdata = {3'h0, state_r.limit[12:8]};
            end
            `IPDP_OFS_AVG_CTRL: begin
               state_nxt.rdata = {state_r.avg_on, 3'h0, state_r.win_exp};
            end
            `IPDP_OFS_POWER_LOW: begin
               state_nxt.rdata = state_r.level[7:0];
            end
            `IPDP_OFS_POWER_HIGH: begin
               state_nxt.rdata = {3'h0, state_r.level[12:8]};
            end
            default: begin
               state_nxt.rdata = `IPDP_RDATA_RESET;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clock_i) begin
      if (srst_i) begin
         state_r         <= '0;
         state_r.limit   <= `IPDP_LIMIT_RESET;
         state_r.win_exp <= `IPDP_EXP_RESET;
         state_r.rdata   <= `IPDP_RDATA_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign reg_rdata_o            = state_r.rdata;
   assign overpower_guard_flag_o = state_r.flag;

endmodule

// [tb/ipdp_top_properties.sv]
`timescale 1ns/10ps
module ipdp_top_properties (
   input wire logic        clock_i,
   input wire logic        srst_i,
   input wire logic        sample_valid_i,
   input wire logic [11:0] reg_addr_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [7:0]  reg_wdata_i,
   input wire logic        irq_clear_i,
   input wire logic [7:0]  reg_rdata_o,
   input wire logic        overpower_guard_flag_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);
   AST_LIMIT_RW: assert property (
      reg_wr_i && reg_addr_i == 12'h060 ##1 !reg_wr_i ##1 reg_rd_i && reg_addr_i == 12'h060
      |=> reg_rdata_o == $past(reg_wdata_i, 3)) else $error("limit readback");
   AST_LIMIT_HIGH: assert property (reg_rd_i && reg_addr_i == 12'h061 |=>
      reg_rdata_o[7:5] == 3'h0) else $error("limit high spare bits");
   AST_CTRL_SPARE: assert property (reg_rd_i && reg_addr_i == 12'h062 |=>
      reg_rdata_o[6:4] == 3'h0) else $error("control spare bits");
   AST_PWR_HIGH: assert property (reg_rd_i && reg_addr_i == 12'h064 |=>
      reg_rdata_o[7:5] == 3'h0) else $error("power high spare bits");
   AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > 12'h064 |=>
      reg_rdata_o == 8'h00) else $error("unmapped read");
   AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("read data moved");
   AST_FLAG_HOLD: assert property (overpower_guard_flag_o && !irq_clear_i
      |=> overpower_guard_flag_o) else $error("flag dropped");
   AST_FLAG_CAUSE: assert property ($rose(overpower_guard_flag_o)
      |-> $past(sample_valid_i, 2)) else $error("flag without window end");
   cover property ($rose(overpower_guard_flag_o));
   cover property (irq_clear_i && overpower_guard_flag_o);
   cover property (reg_rd_i && reg_addr_i == 12'h063);
endmodule

bind ipdp_top ipdp_top_properties ipdp_top_properties_inst (.*);

// [tb/ipdp_upstream.sv]
`timescale 1ns/10ps
module ipdp_upstream (
   input  wire logic        clock_i,
   input  wire logic [5:0]  i_top_i,
   input  wire logic [5:0]  q_top_i,
   input  wire logic [9:0]  noise_i,
   output      logic [15:0] i_sample_o = 16'h0000,
   output      logic [15:0] q_sample_o = 16'h0000,
   output      logic        sample_valid_o = 1'b0
);
   // one pair each cycle; low bits are noise that must not move the power
   always @(posedge clock_i) begin
      i_sample_o     <= {i_top_i, noise_i};
      q_sample_o     <= {q_top_i, ~noise_i};
      sample_valid_o <= 1'b1;
   end
endmodule

// [tb/testbench.sv]
`timescale 1ns/10ps
module testbench;
   logic        clock_i = 1'b0;
   logic        srst_i = 1'b1;
   logic [11:0] addr = 12'h000;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic        pend = 1'b0;
   logic        clr = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic [5:0]  i_top = 6'h00;
   logic [5:0]  q_top = 6'h00;
   logic [31:0] seed = 32'h52db;
   logic [15:0] i_s;
   logic [15:0] q_s;
   logic        valid;
   logic        flag;
   logic [7:0]  rdata;
   logic [7:0]  exp_q[$];
   int          num_errors = 0;
   int          n_compared = 0;
   always #10 clock_i = ~clock_i;
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   always @(posedge clock_i) seed <= xorshift(seed);
   ipdp_upstream ipdp_upstream_inst (.clock_i(clock_i), .i_top_i(i_top), .q_top_i(q_top),
      .noise_i(seed[9:0]), .i_sample_o(i_s), .q_sample_o(q_s), .sample_valid_o(valid));
   ipdp_top ipdp_top_inst (.clock_i(clock_i), .srst_i(srst_i), .i_sample_i(i_s),
      .q_sample_i(q_s), .sample_valid_i(valid), .reg_addr_i(addr), .reg_wr_i(wr),
      .reg_rd_i(rd), .reg_wdata_i(wdata), .irq_clear_i(clr), .reg_rdata_o(rdata),
      .overpower_guard_flag_o(flag));
   // read data lands one cycle after the strobe edge
   always @(posedge clock_i) begin
      if (pend) begin
         n_compared++;
         if (rdata !== exp_q.pop_front()) begin
            num_errors++;
            $display("unexpected read data at %0t", $time);
         end
      end
      pend <= rd;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock_i);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [7:0] e);
      @(posedge clock_i);
      addr <= a;
      rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clock_i);
      rd <= 1'b0;
   endtask
   task automatic rd_pwr(input logic [12:0] p);
      rd_reg(12'h063, p[7:0]);
      rd_reg(12'h064, {3'h0, p[12:8]});
   endtask
   task automatic chk_flag(input logic e);
      // look away from the launching edge so the flag has settled
      @(negedge clock_i);
      n_compared++;
      if (flag !== e) begin
         num_errors++;
         $display("unexpected flag at %0t", $time);
      end
   endtask
   task automatic results();
      if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      logic [7:0] r;
      tick(10);
      srst_i <= 1'b0;
      for (int a = 'h060; a <= 'h065; a++) rd_reg(12'(a), 8'h00);
      r = seed[7:0];
      wr_reg(12'h060, r);
      rd_reg(12'h060, r);
      wr_reg(12'h061, 8'hff);
      rd_reg(12'h061, 8'h1f);
      wr_reg(12'h062, r & 8'h7f);
      rd_reg(12'h062, r & 8'h0f);
      wr_reg(12'h063, 8'haa);
      rd_reg(12'h063, 8'h00);
      wr_reg(12'h060, 8'hff);
      wr_reg(12'h062, 8'h00);
      i_top <= 6'h10;
      q_top <= 6'h38;
      tick(600);
      rd_pwr(13'h0000);
      wr_reg(12'h062, 8'h80);
      tick(1100);
      rd_pwr(13'h0140);
      chk_flag(1'b0);
      wr_reg(12'h061, 8'h01);
      wr_reg(12'h060, 8'h3f);
      tick(1100);
      chk_flag(1'b1);
      i_top <= 6'h08;
      q_top <= 6'h00;
      tick(1100);
      rd_pwr(13'h0140);
      chk_flag(1'b1);
      clr <= 1'b1;
      tick(1);
      clr <= 1'b0;
      tick(1100);
      chk_flag(1'b0);
      rd_pwr(13'h0040);
      // exponent 1: a 1024-pair window must not update at 512 pairs
      wr_reg(12'h061, 8'h1f);
      wr_reg(12'h060, 8'hff);
      i_top <= 6'h20;
      q_top <= 6'h00;
      wr_reg(12'h062, 8'h00);
      wr_reg(12'h062, 8'h81);
      tick(700);
      rd_pwr(13'h0040);
      tick(400);
      rd_pwr(13'h0400);
      chk_flag(1'b0);
      results();
   end
   initial begin
      tick(20000);
      num_errors++;
      results();
   end
endmodule
